//--- common/tpo_defs.vh
`ifndef TPO_DEFS_VH
`define TPO_DEFS_VH

// Register byte addresses
`define TPO_ADDR_VALUE      12'h000
`define TPO_ADDR_NEXT       12'h004
`define TPO_ADDR_DIR        12'h008
`define TPO_ADDR_NEXT_EN    12'h00c
`define TPO_ADDR_TRIG_SEL   12'h010
`define TPO_ADDR_MODE       12'h014
`define TPO_ADDR_CAPTURE    12'h018
`define TPO_ADDR_ALT_EN     12'h01c
`define TPO_ADDR_PINS       12'h020

// Reset values
`define TPO_RST_TRIG_SEL    8'hff
`define TPO_RST_MODE        4'h0
`define TPO_RST_HALF        16'h0000

// Field widths
`define TPO_GRP_W           4
`define TPO_SEL_W           2

`endif

//--- core/tpo_group.v
`timescale 1ns/1ns
`default_nettype none
`include "tpo_defs.vh"

module tpo_group #(
    parameter CHANNELS = 4                           // Timer channels
) (
    input  wire [CHANNELS-1:0]        match_a,       // Compare match A strobes
    input  wire [CHANNELS-1:0]        match_b,       // Compare match B strobes
    input  wire [CHANNELS-1:0]        capture_a,     // Input capture A strobes
    input  wire [CHANNELS-1:0]        capture_mode,  // Channel register A captures
    input  wire [`TPO_SEL_W-1:0]      trig_sel,      // Selected channel
    input  wire                       nonoverlap,    // Non-overlap mode
    input  wire [`TPO_GRP_W-1:0]      next_val,      // Next values
    output reg  [`TPO_GRP_W-1:0]      load_mask      // Bits to copy this cycle
);

    reg ev_a;
    reg ev_b;

    // Select trigger source and form copy mask
    always @* begin
        ev_a = capture_mode[trig_sel] ? capture_a[trig_sel] : match_a[trig_sel];
        ev_b = match_b[trig_sel];
        if (ev_a) begin
            load_mask = {`TPO_GRP_W{1'b1}};
        end else if (nonoverlap && ev_b) begin
            load_mask = ~next_val;
        end else begin
            load_mask = {`TPO_GRP_W{1'b0}};
        end
    end

endmodule // tpo_group
`default_nettype wire

//--- core/tpo_top.v
// Summary of operation
// - Pin drives pattern when direction set; enable does not gate the copy
// - Enabled pin shows current value register
// - Trigger copies next value into value register
// - Enable without direction: input, value read-only
// - Capture-mode channel triggers on input capture
// - Alternate function owns pin; copy continues
// - Non-overlap match A copies all bits
// - Non-overlap match B copies only zero bits
// - Falls at match B, rises at match A
// - Two-bit select per group, resets channel 3
// - Normal mode changes only at match A, or capture A in capture mode
// - Period from register B, margin from A
`timescale 1ns/1ns
`default_nettype none
`include "tpo_defs.vh"

module tpo_top #(
    parameter GROUPS   = 4,                          // Four-bit output groups
    parameter CHANNELS = 4                           // Timer channels
) (
    input  wire                       core_clk,      // System clock
    input  wire                       rst_n,         // Async reset, active low
    input  wire                       psel,          // APB select
    input  wire                       penable,       // APB enable
    input  wire                       pwrite,        // APB write
    input  wire [11:0]                paddr,         // APB byte address
    input  wire [31:0]                pwdata,        // APB write data
    output reg  [31:0]                prdata,        // APB read data
    output reg                        pready,        // APB ready
    output reg                        pslverr,       // APB error
    input  wire [CHANNELS-1:0]        match_a,       // Compare match A strobes
    input  wire [CHANNELS-1:0]        match_b,       // Compare match B strobes
    input  wire [CHANNELS-1:0]        capture_a,     // Input capture A strobes
    input  wire [CHANNELS-1:0]        capture_mode,  // Channel register A in capture
    input  wire [GROUPS*4-1:0]        alt_out_en,    // Timer or DMA owns pin
    input  wire [GROUPS*4-1:0]        alt_out,       // Timer or DMA pin value
    input  wire [GROUPS*4-1:0]        pin_in,        // Pin input levels
    output reg  [GROUPS*4-1:0]        pin_out,       // Pin output levels
    output reg  [GROUPS*4-1:0]        pin_oe         // Pin output enables
);

    // Pin count and field widths
    localparam GW = `TPO_GRP_W;                      // Pins per group
    localparam SW = `TPO_SEL_W;                      // Select bits per group
    localparam W  = GROUPS * GW;                     // Pattern pins in all

    // Software-visible registers
    reg  [W-1:0]          port_value;                // Value register
    reg  [W-1:0]          next_value;                // Buffered next pattern
    reg  [W-1:0]          port_dir;                  // Direction, 1 = output
    reg  [W-1:0]          next_out_enable;           // Write lock per pin where direction is clear
    reg  [SW*GROUPS-1:0]  trigger_select;            // Channel per group
    reg  [GROUPS-1:0]     overlap_mode;              // Non-overlap bit per group

    // Pin input synchroniser stages
    reg  [W-1:0]          pin_meta;                  // First stage, read by second only
    reg  [W-1:0]          pin_sync;                  // Second stage

    // Trigger copy and bus decode
    wire [W-1:0]          load_mask;                 // Bits copied this cycle
    wire                  wr_en;                     // Write in access phase
    reg                   addr_ok;                   // Offset is mapped
    reg  [31:0]           rd_mux;                    // Read data before register

    // Next values of registers and outputs
    reg  [W-1:0]          next_port_value;           // Value register
    reg  [W-1:0]          wr_mask;                   // Software-writable value bits
    reg  [W-1:0]          next_pin_out;              // Pin levels
    reg  [W-1:0]          next_pin_oe;               // Pin drive enables
    reg                   next_pready;               // Bus ready
    reg                   next_pslverr;              // Bus error
    reg  [31:0]           next_prdata;               // Bus read data

    // Per-group trigger decode; each group has its own channel and mode
    // A group copies only in the cycle its selected strobe is high
    genvar g;
    generate
        for (g = 0; g < GROUPS; g = g + 1) begin : grp
            tpo_group #(
                .CHANNELS     (CHANNELS)
            ) u_grp (
                .match_a      (match_a),
                .match_b      (match_b),
                .capture_a    (capture_a),
                .capture_mode (capture_mode),
                .trig_sel     (trigger_select[SW*g +: SW]),
                .nonoverlap   (overlap_mode[g]),
                .next_val     (next_value[GW*g +: GW]),
                .load_mask    (load_mask[GW*g +: GW])
            );
        end
    endgenerate

    // Pin synchronisers; pin_in is asynchronous to core_clk
    // Timer-side inputs share core_clk and are used directly
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= {W{1'b0}};
            pin_sync <= {W{1'b0}};
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Write strobe, taken in the access phase
    assign wr_en = psel && penable && pwrite;

    // Value register next state
    always @* begin
        // Bits with enable set and direction clear ignore writes
        wr_mask = ~(next_out_enable & ~port_dir);
        next_port_value = port_value;
        // Software write, masked per bit
        if (wr_en && paddr == `TPO_ADDR_VALUE) begin
            next_port_value = (port_value & ~wr_mask) | (pwdata[W-1:0] & wr_mask);
        end
        // Trigger copy happens in strobe cycle and wins over software
        next_port_value = (next_port_value & ~load_mask) |
                          (next_value & load_mask);
    end

    // Register file and value register; select resets to channel 3
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_value      <= `TPO_RST_HALF;
            next_value      <= `TPO_RST_HALF;
            port_dir        <= `TPO_RST_HALF;
            next_out_enable <= `TPO_RST_HALF;
            trigger_select  <= `TPO_RST_TRIG_SEL;
            overlap_mode    <= `TPO_RST_MODE;
        end else begin
            // Value register follows its next state
            port_value <= next_port_value;
            // Writes land at the access edge; read-only offsets ignored
            if (wr_en) begin
                case (paddr)
                    `TPO_ADDR_NEXT:     next_value      <= pwdata[W-1:0];
                    `TPO_ADDR_DIR:      port_dir        <= pwdata[W-1:0];
                    `TPO_ADDR_NEXT_EN:  next_out_enable <= pwdata[W-1:0];
                    `TPO_ADDR_TRIG_SEL: trigger_select  <= pwdata[SW*GROUPS-1:0];
                    `TPO_ADDR_MODE:     overlap_mode    <= pwdata[GROUPS-1:0];
                    default:            ;
                endcase
            end
        end
    end

    // Address decode and read mux; unused upper bits read as zero
    always @* begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        // Readback-only offsets give no error
        case (paddr)
            `TPO_ADDR_VALUE:    rd_mux[W-1:0]        = port_value;
            `TPO_ADDR_NEXT:     rd_mux[W-1:0]        = next_value;
            `TPO_ADDR_DIR:      rd_mux[W-1:0]        = port_dir;
            `TPO_ADDR_NEXT_EN:  rd_mux[W-1:0]        = next_out_enable;
            `TPO_ADDR_TRIG_SEL: rd_mux[SW*GROUPS-1:0] = trigger_select;
            `TPO_ADDR_MODE:     rd_mux[GROUPS-1:0]   = overlap_mode;
            `TPO_ADDR_CAPTURE:  rd_mux[CHANNELS-1:0] = capture_mode;
            `TPO_ADDR_ALT_EN:   rd_mux[W-1:0]        = alt_out_en;
            `TPO_ADDR_PINS:     rd_mux[W-1:0]        = pin_sync;
            default:            addr_ok              = 1'b0;
        endcase
    end

    // APB answer: ready in the first access cycle, no wait state
    always @* begin
        // Ready after every setup cycle
        next_pready  = psel && !penable;
        // Error only for unmapped offsets
        next_pslverr = psel && !penable && !addr_ok;
        // Read data only for reads, else zero
        next_prdata  = (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
    end

    // Answer stands for one cycle only
    // Read data latched in setup stands with pready
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // Pin drive next state
    always @* begin
        // Value register after this cycle's copy
        next_pin_out = next_port_value;
        // Alternate function owns the pin's value and drive
        next_pin_out = (next_pin_out & ~alt_out_en) | (alt_out & alt_out_en);
        // Direction or alt_out_en enables the driver; the pattern copy ignores enable
        next_pin_oe  = port_dir | alt_out_en;
    end

    // Registered pin levels and drive enables
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= {W{1'b0}};
            pin_oe  <= {W{1'b0}};
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

endmodule // tpo_top
`default_nettype wire

//--- testbench/tpo_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tpo_checker #(
    parameter GROUPS   = 4,                       // Output groups
    parameter CHANNELS = 4                        // Timer channels
) (
    input wire logic                  core_clk,   // Clock
    input wire logic                  rst_n,      // Reset
    input wire logic                  psel,       // Select
    input wire logic                  penable,    // Enable
    input wire logic                  pwrite,     // Write
    input wire logic [31:0]           prdata,     // Read data
    input wire logic                  pready,     // Ready
    input wire logic                  pslverr,    // Error
    input wire logic [CHANNELS-1:0]   match_a,    // Match A
    input wire logic [CHANNELS-1:0]   match_b,    // Match B
    input wire logic [CHANNELS-1:0]   capture_a,  // Capture A
    input wire logic [GROUPS*4-1:0]   alt_out_en, // Alternate owns pin
    input wire logic [GROUPS*4-1:0]   alt_out,    // Alternate value
    input wire logic [GROUPS*4-1:0]   pin_out,    // Pin value
    input wire logic [GROUPS*4-1:0]   pin_oe      // Pin drive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // No bus, trigger or alternate activity
    wire quiet = !psel && !(|{match_a, match_b, capture_a}) && alt_out_en == 0;
    ready_no_wait_a: assert property (psel && !penable |=> pready)
        else $error("ready not in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready || pwrite |-> prdata == 0)
        else $error("read data outside read answer");
    alt_drive_a: assert property (1 |=> (pin_oe & $past(alt_out_en)) == $past(alt_out_en))
        else $error("alternate pin not driven");
    alt_value_a: assert property (1 |=> ((pin_out ^ $past(alt_out)) & $past(alt_out_en)) == 0)
        else $error("alternate pin value wrong");
    quiet_hold_a: assert property (quiet [*2] |=> $stable(pin_out) && $stable(pin_oe))
        else $error("pins moved without trigger");
    cover property (pslverr);
    cover property (|match_b);
    cover property (|capture_a);
endmodule // tpo_checker
bind tpo_top tpo_checker #(.GROUPS(GROUPS), .CHANNELS(CHANNELS)) i_tpo_checker (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .match_a(match_a), .match_b(match_b), .capture_a(capture_a),
    .alt_out_en(alt_out_en), .alt_out(alt_out), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

//--- testbench/tpo_load.sv
`timescale 1ns/1ns
`default_nettype none
module tpo_load (
    input  wire logic [15:0] pin_out, // Pin value
    input  wire logic [15:0] pin_oe,  // Pin drive
    output wire logic [15:0] pin_in   // Pin level
);
    // Driven pins echo, floating pins show the inverse
    assign pin_in = (pin_out & pin_oe) | (~pin_out & ~pin_oe);
endmodule // tpo_load
`default_nettype wire

//--- testbench/timed_pattern_output_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpo_defs.vh"
module timed_pattern_output_tb_top;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] match_a = 0, match_b = 0, capture_a = 0, capture_mode = 0;
    logic [15:0] alt_out_en = 0, alt_out = 0, pin_in, pin_out, pin_oe, nv, cur;
    logic [64:0] exp_q[$], e;
    int err_total = 0, comparisons = 0, seed = 60174;
    always #2 core_clk = ~core_clk;
    tpo_top i_tpo_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .match_a(match_a),
        .match_b(match_b), .capture_a(capture_a), .capture_mode(capture_mode), .alt_out_en(alt_out_en),
        .alt_out(alt_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    tpo_load i_tpo_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One bus transfer; a read notes its expected answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [64:0] x);
        int n;
        if (!w) exp_q.push_back(x);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk) penable <= 1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge core_clk);
        if (n == 20) begin
            err_total++;
            finish_test;
        end else begin
            psel <= 0;
            penable <= 0;
            @(posedge core_clk);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        apb(0, a, 0, {1'b0, 32'hffffffff, v});
    endtask
    // Strobe kind k on channels ch, then read back the synced pins
    task automatic trig(input int k, input logic [3:0] ch, input logic [15:0] x);
        {match_a, match_b, capture_a} <= {ch & {4{k == 0}}, ch & {4{k == 1}}, ch & {4{k == 2}}};
        @(posedge core_clk) {match_a, match_b, capture_a} <= 0;
        repeat (4) @(posedge core_clk);
        rd(`TPO_ADDR_PINS, {16'h0000, x});
    endtask
    // Compare each read answer with the oldest note
    always @(posedge core_clk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            e = exp_q.pop_front();
            check({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
        end
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        rd(`TPO_ADDR_TRIG_SEL, 32'h000000ff);
        rd(`TPO_ADDR_MODE, 32'h0);
        apb(0, 12'h040, 0, {1'b1, 32'hffffffff, 32'h0});
        apb(1, `TPO_ADDR_DIR, 32'hffff, 0);
        apb(1, `TPO_ADDR_NEXT_EN, 32'hffff, 0);
        apb(1, `TPO_ADDR_VALUE, 32'h1234, 0);
        cur = 16'h1234;
        nv = $random(seed);
        apb(1, `TPO_ADDR_NEXT, nv, 0);
        trig(1, 4'hf, cur);
        trig(0, 4'h7, cur);
        cur = nv;
        trig(0, 4'h8, cur);
        apb(1, `TPO_ADDR_TRIG_SEL, 32'he4, 0);
        for (int c = 0; c < 4; c++) begin
            nv = $random(seed);
            apb(1, `TPO_ADDR_NEXT, nv, 0);
            cur[4*c +: 4] = nv[4*c +: 4];
            trig(0, 4'h1 << c, cur);
        end
        apb(1, `TPO_ADDR_MODE, 32'hf, 0);
        nv = $random(seed);
        apb(1, `TPO_ADDR_NEXT, nv, 0);
        cur = cur & nv;
        trig(1, 4'hf, cur);
        cur = nv;
        trig(0, 4'hf, cur);
        apb(1, `TPO_ADDR_MODE, 32'h0, 0);
        capture_mode <= 4'hf;
        nv = ~cur;
        apb(1, `TPO_ADDR_NEXT, nv, 0);
        apb(1, `TPO_ADDR_CAPTURE, 0, 0);
        rd(`TPO_ADDR_CAPTURE, 32'hf);
        trig(0, 4'hf, cur);
        trig(2, 4'hf, nv);
        capture_mode <= 4'h0;
        apb(1, `TPO_ADDR_DIR, 32'h0, 0);
        apb(1, `TPO_ADDR_VALUE, ~nv, 0);
        rd(`TPO_ADDR_VALUE, nv);
        nv = $random(seed);
        apb(1, `TPO_ADDR_NEXT, nv, 0);
        trig(0, 4'hf, ~nv);
        apb(1, `TPO_ADDR_DIR, 32'hffff, 0);
        alt_out_en <= 16'h00ff;
        alt_out <= $random(seed);
        nv = $random(seed);
        apb(1, `TPO_ADDR_NEXT, nv, 0);
        trig(0, 4'hf, {nv[15:8], alt_out[7:0]});
        rd(`TPO_ADDR_ALT_EN, 32'h00ff);
        rd(`TPO_ADDR_VALUE, nv);
        finish_test;
    end
endmodule // timed_pattern_output_tb_top
`default_nettype wire
